// [src/spif_pkg.sv]
// Shared constants, message text and state type of the serial printer interface
package spif_pkg;

	// System clock and line rate
	localparam int unsigned CLK_HZ       = 125_000_000;
	localparam int unsigned MAX_BAUD     = 19_200;
	// Bit time rounds down so the line never runs slower than the rate
	localparam int unsigned BIT_CYC_DFLT = CLK_HZ / MAX_BAUD;

	// Message buffer and data-path FIFO
	localparam int unsigned BUF_BYTES  = 8192;
	localparam int unsigned BUF_AW     = 13;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned DATA_W     = 8;

	// Flow control marks, in stored bytes
	localparam logic [13:0] HI_MARK = 14'h1f00;
	localparam logic [13:0] LO_MARK = 14'h0100;

	// In-band flow control and loopback character codes
	localparam logic [7:0] XON_CHAR   = 8'h11;
	localparam logic [7:0] XOFF_CHAR  = 8'h13;
	localparam logic [7:0] LOOP_FIRST = 8'h20;
	localparam logic [7:0] LOOP_LAST  = 8'h7f;

	// Control line settle time before looped inputs are judged
	localparam int unsigned SETTLE_NS  = 1000;
	localparam int unsigned SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	// Init lasts this many cycles plus one, enough for the input synchronisers to fill
	localparam int unsigned INIT_CYC   = 4;
	// Bit times waited from the start of the last loopback character
	localparam int unsigned LOOP_WAIT_BITS = 30;

	// Reset value of synchronised pins; receive data idles high
	localparam logic [6:0] SYNC_RST = 7'h40;

	// Self-test message text, packed back to back
	localparam int unsigned MSG_CHARS = 25;
	localparam logic [8*MSG_CHARS-1:0] MSG_TEXT = "LOOP TESTOKBADIF OKIF BAD";
	localparam logic [4:0] MSG_LOOP_S  = 5'd0;
	localparam logic [4:0] MSG_LOOP_E  = 5'd8;
	localparam logic [4:0] MSG_OK_S    = 5'd9;
	localparam logic [4:0] MSG_OK_E    = 5'd10;
	localparam logic [4:0] MSG_BAD_S   = 5'd11;
	localparam logic [4:0] MSG_BAD_E   = 5'd13;
	localparam logic [4:0] MSG_IFOK_S  = 5'd14;
	localparam logic [4:0] MSG_IFOK_E  = 5'd18;
	localparam logic [4:0] MSG_IFBAD_S = 5'd19;
	localparam logic [4:0] MSG_IFBAD_E = 5'd24;

	// Sequencer states
	typedef enum logic [3:0] {
		ST_INIT, ST_RUN, ST_REV, ST_MSG, ST_MWR, ST_MRD, ST_MEND,
		ST_LINE, ST_LOOP, ST_LWAIT, ST_DRAIN
	} spif_state_t;

endpackage

// [src/spif_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module spif_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             reset_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW:0]      wr_reg;
	logic [AW:0]      rd_reg;
	logic             push;
	logic             pop;

	// Extra pointer bit tells full from empty
	assign in_ready  = (wr_reg[AW] == rd_reg[AW]) || (wr_reg[AW-1:0] != rd_reg[AW-1:0]);
	assign out_valid = (wr_reg != rd_reg);
	assign out_data  = store[rd_reg[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Storage write
	always_ff @(posedge sys_clk) begin
		if (push) begin
			store[wr_reg[AW-1:0]] <= in_data;
		end
	end

	// Pointers
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else begin
			if (push) begin
				wr_reg <= wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= rd_reg + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// [src/spif_top.sv]
// Serial printer interface: line engine, message buffer, flow control, self-test
//
// Contract
// - Full-duplex start-stop transmit and receive up to 19,200 bit/s.
// - Ready/busy line or X-ON/X-OFF flow control, chosen; host obeys it.
// - Received bytes wait in an 8192-byte buffer, then go out in parallel.
// - Held in reset by printer reset; after release set timer and mode.
// - Drive terminal ready, busy status, transmit data and request to send.
// - Sample set ready, clear to send, carrier detect and receive data.
// - Diagnostic mode at power-up runs self-test; select switch starts, stops it.
// - Each pass prints two revision digits, then the loop-test banner.
// - Check buffer memory, print pass or fail string.
// - Drive three control outputs low; pass only if three inputs read low.
// - Drive three control outputs high; pass only if three inputs read high.
// - Send codes 20H to 7FH while receiving them into the buffer.
// - Then print the characters received and stored in the buffer.
// - The whole pass repeats until the operator interrupts it.
`timescale 1ns/1ps
`default_nettype none
module spif_top
	import spif_pkg::*;
#(
	parameter int unsigned BIT_CYC = spif_pkg::BIT_CYC_DFLT,
	parameter logic [15:0] FW_REV  = 16'h3031 // Arbitrary revision digits
) (
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire logic       rxd_in,
	input  wire logic       dsr_in,
	input  wire logic       cts_in,
	input  wire logic       cd_in,
	input  wire logic       diag_mode,
	input  wire logic       sel_switch,
	input  wire logic       xon_mode,
	input  wire logic       prn_ready,
	output logic            txd_out,
	output logic            dtr_out,
	output logic            rts_out,
	output logic            secondary_busy_status_out,
	output logic [7:0]      prn_data,
	output logic            prn_valid,
	output logic            rx_overrun
);
	localparam logic [15:0] BIT_LEN   = 16'(BIT_CYC);
	localparam logic [23:0] LWAIT_CYC = 24'(BIT_CYC * LOOP_WAIT_BITS);

	logic [6:0]          sync1_reg;
	logic [6:0]          sync2_reg;
	logic                sel_d_reg;
	logic                rxd_s, dsr_s, cts_s, cd_s, diag_s, sel_s, xon_s;
	spif_state_t         state_reg;
	spif_state_t         ret_reg;
	logic [4:0]          msg_idx_reg;
	logic [4:0]          msg_last_reg;
	logic                rev_idx_reg;
	logic                line_hi_reg;
	logic                test_on_reg;
	logic                mode_xon_reg;
	logic [15:0]         bit_len_reg;
	logic [23:0]         wait_reg;
	logic [BUF_AW-1:0]   chk_addr_reg;
	logic                chk_v_reg;
	logic [7:0]          exp_reg;
	logic                mem_bad_reg;
	logic [7:0]          loop_ch_reg;
	logic [7:0]          mem [BUF_BYTES];
	logic [7:0]          mem_q_reg;
	logic [BUF_AW-1:0]   wr_ptr_reg;
	logic [BUF_AW-1:0]   rd_ptr_reg;
	logic [13:0]         cnt_reg;
	logic                rd_pend_reg;
	logic                busy_reg;
	logic                xoff_sent_reg;
	logic [9:0]          tx_sh_reg;
	logic [3:0]          tx_bits_reg;
	logic [15:0]         tx_cnt_reg;
	logic                tx_busy_reg;
	logic                rx_act_reg;
	logic [15:0]         rx_cnt_reg;
	logic [3:0]          rx_bits_reg;
	logic [7:0]          rx_sh_reg;
	logic                rx_push_reg;
	logic                fifo_in_ready;
	logic                fifo_out_valid;
	logic                fifo_out_ready;
	logic [7:0]          fifo_out_data;
	logic                fifo_take;
	logic                out_free;
	logic                drain_go;
	logic                tst_put;
	logic [7:0]          tst_char;
	logic                tx_go;
	logic [7:0]          tx_byte;
	logic                tx_take;
	logic                mem_we;
	logic                mem_re;
	logic [BUF_AW-1:0]   mem_wa;
	logic [BUF_AW-1:0]   mem_ra;
	logic [7:0]          mem_wd;
	logic                memchk;
	logic                in_test;
	logic [7:0]          pat;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_reg <= SYNC_RST;
			sync2_reg <= SYNC_RST;
			sel_d_reg <= 1'b0;
		end else begin
			sync1_reg <= {rxd_in, dsr_in, cts_in, cd_in, diag_mode, sel_switch, xon_mode};
			sync2_reg <= sync1_reg;
			sel_d_reg <= sel_s;
		end
	end
	assign {rxd_s, dsr_s, cts_s, cd_s, diag_s, sel_s, xon_s} = sync2_reg;

	// Shared strobes of the data path
	assign memchk   = (state_reg == ST_MWR) || (state_reg == ST_MRD) || (state_reg == ST_MEND);
	assign in_test  = (state_reg != ST_RUN) && (state_reg != ST_INIT);
	assign out_free = !prn_valid || prn_ready;
	// Buffer full or memory check holds the FIFO, which then fills
	assign fifo_out_ready = !memchk && (cnt_reg != 14'(BUF_BYTES));
	assign fifo_take = fifo_out_valid && fifo_out_ready;
	assign drain_go = ((state_reg == ST_RUN) || (state_reg == ST_DRAIN)) && (cnt_reg != 14'h0)
		&& !rd_pend_reg && !prn_valid;
	assign pat = chk_addr_reg[7:0] ^ {3'h0, chk_addr_reg[12:8]};

	// Characters printed by the self-test
	always_comb begin
		tst_put  = 1'b0;
		tst_char = 8'h00;
		if (out_free && !rd_pend_reg) begin
			if (state_reg == ST_REV) begin
				tst_put  = 1'b1;
				tst_char = rev_idx_reg ? FW_REV[7:0] : FW_REV[15:8];
			end else if (state_reg == ST_MSG) begin
				tst_put  = 1'b1;
				tst_char = MSG_TEXT[(MSG_CHARS - 1 - int'(msg_idx_reg)) * 8 +: 8];
			end
		end
	end

	// Buffer memory port steering
	always_comb begin
		mem_we = fifo_take || (state_reg == ST_MWR);
		mem_wa = (state_reg == ST_MWR) ? chk_addr_reg : wr_ptr_reg;
		mem_wd = (state_reg == ST_MWR) ? pat : fifo_out_data;
		mem_re = drain_go || (state_reg == ST_MRD);
		mem_ra = (state_reg == ST_MRD) ? chk_addr_reg : rd_ptr_reg;
	end

	// Buffer memory, no reset
	always_ff @(posedge sys_clk) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
		if (mem_re) begin
			mem_q_reg <= mem[mem_ra];
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg    <= 14'h0;
		end else if (state_reg == ST_MEND) begin
			wr_ptr_reg <= '0; // Check has overwritten the contents
			rd_ptr_reg <= '0;
			cnt_reg    <= 14'h0;
		end else begin
			if (fifo_take) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (drain_go) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			case ({fifo_take, drain_go})
				2'b10:   cnt_reg <= cnt_reg + 14'h1;
				2'b01:   cnt_reg <= cnt_reg - 14'h1;
				default: cnt_reg <= cnt_reg;
			endcase
		end
	end

	// Printer parallel output
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_pend_reg <= 1'b0;
			prn_valid   <= 1'b0;
			prn_data    <= 8'h00;
		end else begin
			rd_pend_reg <= drain_go;
			if (rd_pend_reg) begin
				prn_valid <= 1'b1;
				prn_data  <= mem_q_reg;
			end else if (tst_put) begin
				prn_valid <= 1'b1;
				prn_data  <= tst_char;
			end else if (prn_ready) begin
				prn_valid <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_reg <= 1'b0;
		end else if (cnt_reg >= HI_MARK) begin
			busy_reg <= 1'b1;
		end else if (cnt_reg <= LO_MARK) begin
			busy_reg <= 1'b0;
		end
	end

	// Transmit source: loopback codes, else flow characters
	always_comb begin
		tx_go   = 1'b0;
		tx_byte = 8'h00;
		if (state_reg == ST_LOOP) begin
			tx_go   = 1'b1;
			tx_byte = loop_ch_reg;
		end else if ((state_reg == ST_RUN) && mode_xon_reg && (busy_reg != xoff_sent_reg)) begin
			tx_go   = 1'b1;
			tx_byte = busy_reg ? XOFF_CHAR : XON_CHAR;
		end
	end
	assign tx_take = tx_go && !tx_busy_reg;

	// Record which flow character went out last
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			xoff_sent_reg <= 1'b0;
		end else if (tx_take && (state_reg == ST_RUN)) begin
			xoff_sent_reg <= busy_reg;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_sh_reg   <= 10'h3ff;
			tx_bits_reg <= 4'h0;
			tx_cnt_reg  <= 16'h0;
			tx_busy_reg <= 1'b0;
			txd_out     <= 1'b1;
		end else begin
			txd_out <= tx_busy_reg ? tx_sh_reg[0] : 1'b1;
			if (tx_take) begin
				tx_sh_reg   <= {1'b1, tx_byte, 1'b0};
				tx_bits_reg <= 4'd10;
				tx_cnt_reg  <= 16'h0;
				tx_busy_reg <= 1'b1;
			end else if (tx_busy_reg) begin
				if (tx_cnt_reg == bit_len_reg - 16'h1) begin
					tx_cnt_reg  <= 16'h0;
					tx_sh_reg   <= {1'b1, tx_sh_reg[9:1]};
					tx_bits_reg <= tx_bits_reg - 4'h1;
					tx_busy_reg <= (tx_bits_reg != 4'h1);
				end else begin
					tx_cnt_reg <= tx_cnt_reg + 16'h1;
				end
			end
		end
	end

	// receiver, samples at mid-bit, false start rejected
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_act_reg  <= 1'b0;
			rx_cnt_reg  <= 16'h0;
			rx_bits_reg <= 4'h0;
			rx_sh_reg   <= 8'h00;
			rx_push_reg <= 1'b0;
		end else begin
			rx_push_reg <= 1'b0;
			if (!rx_act_reg) begin
				rx_act_reg  <= !rxd_s;
				rx_cnt_reg  <= 16'h0;
				rx_bits_reg <= 4'h0;
			end else if (((rx_bits_reg == 4'h0) && (rx_cnt_reg == (bit_len_reg >> 1)))
				|| ((rx_bits_reg != 4'h0) && (rx_cnt_reg == bit_len_reg - 16'h1))) begin
				rx_cnt_reg  <= 16'h0;
				rx_bits_reg <= rx_bits_reg + 4'h1;
				if (rx_bits_reg == 4'h0) begin
					rx_act_reg <= !rxd_s;
				end else if (rx_bits_reg == 4'd9) begin
					rx_act_reg  <= 1'b0;
					rx_push_reg <= rxd_s; // Framing error drops the byte
				end else begin
					rx_sh_reg <= {rxd_s, rx_sh_reg[7:1]};
				end
			end else begin
				rx_cnt_reg <= rx_cnt_reg + 16'h1;
			end
		end
	end

	// Receiver cannot stall; a full FIFO costs the byte
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_overrun <= 1'b0;
		end else if (rx_push_reg && !fifo_in_ready) begin
			rx_overrun <= 1'b1;
		end else if (state_reg == ST_MEND) begin
			rx_overrun <= 1'b0;
		end
	end

	// Receive FIFO ahead of the buffer
	spif_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.reset_n   (reset_n),
		.in_valid  (rx_push_reg),
		.in_ready  (fifo_in_ready),
		.in_data   (rx_sh_reg),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			dtr_out                   <= 1'b0;
			rts_out                   <= 1'b0;
			secondary_busy_status_out <= 1'b0;
		end else if (in_test) begin
			dtr_out                   <= line_hi_reg;
			rts_out                   <= line_hi_reg;
			secondary_busy_status_out <= line_hi_reg;
		end else begin
			dtr_out                   <= 1'b1;
			rts_out                   <= 1'b1;
			secondary_busy_status_out <= mode_xon_reg || !busy_reg;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			test_on_reg <= 1'b0;
		end else if (state_reg == ST_INIT) begin
			test_on_reg <= diag_s;
		end else if (sel_s && !sel_d_reg && diag_s) begin
			test_on_reg <= !test_on_reg;
		end
	end

	// Wait counter for init, settling and loopback tail
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wait_reg <= 24'h0;
		end else if ((state_reg == ST_INIT) || (state_reg == ST_LINE) || (state_reg == ST_LWAIT)) begin
			wait_reg <= wait_reg + 24'h1;
		end else begin
			wait_reg <= 24'h0;
		end
	end

	// Memory check compare, one cycle behind the read
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			chk_v_reg   <= 1'b0;
			exp_reg     <= 8'h00;
			mem_bad_reg <= 1'b0;
		end else begin
			chk_v_reg <= (state_reg == ST_MRD);
			exp_reg   <= pat;
			if (state_reg == ST_REV) begin
				mem_bad_reg <= 1'b0;
			end else if (chk_v_reg && (mem_q_reg != exp_reg)) begin
				mem_bad_reg <= 1'b1;
			end
		end
	end

	// Sequencer: init, normal run and self-test pass
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg    <= ST_INIT;
			ret_reg      <= ST_RUN;
			msg_idx_reg  <= 5'h0;
			msg_last_reg <= 5'h0;
			rev_idx_reg  <= 1'b0;
			line_hi_reg  <= 1'b0;
			mode_xon_reg <= 1'b0;
			bit_len_reg  <= 16'h1;
			chk_addr_reg <= '0;
			loop_ch_reg  <= LOOP_FIRST;
		end else begin
			case (state_reg)
				ST_INIT: begin
					// set bit timer and serial mode
					bit_len_reg  <= BIT_LEN;
					mode_xon_reg <= xon_s;
					if (wait_reg == 24'(INIT_CYC)) begin
						state_reg <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (test_on_reg) begin
						state_reg   <= ST_REV;
						rev_idx_reg <= 1'b0;
						line_hi_reg <= 1'b0;
					end
				end
				ST_REV: begin
					if (tst_put) begin
						rev_idx_reg <= 1'b1;
						if (rev_idx_reg) begin
							msg_idx_reg  <= MSG_LOOP_S;
							msg_last_reg <= MSG_LOOP_E;
							ret_reg      <= ST_MWR;
							chk_addr_reg <= '0;
							state_reg    <= ST_MSG;
						end
					end
				end
				ST_MSG: begin
					if (tst_put) begin
						msg_idx_reg <= msg_idx_reg + 5'h1;
						if (msg_idx_reg == msg_last_reg) begin
							state_reg <= ret_reg;
						end
					end
				end
				ST_MWR: begin
					chk_addr_reg <= chk_addr_reg + 1'b1;
					if (&chk_addr_reg) begin
						state_reg <= ST_MRD;
					end
				end
				ST_MRD: begin
					chk_addr_reg <= chk_addr_reg + 1'b1;
					if (&chk_addr_reg) begin
						state_reg <= ST_MEND;
					end
				end
				ST_MEND: begin
					if (mem_bad_reg || (mem_q_reg != exp_reg)) begin
						msg_idx_reg  <= MSG_BAD_S;
						msg_last_reg <= MSG_BAD_E;
					end else begin
						msg_idx_reg  <= MSG_OK_S;
						msg_last_reg <= MSG_OK_E;
					end
					ret_reg   <= ST_LINE;
					state_reg <= ST_MSG;
				end
				ST_LINE: begin
					if (wait_reg == 24'(SETTLE_CYC)) begin
						if ({dsr_s, cts_s, cd_s} == {3{line_hi_reg}}) begin
							msg_idx_reg  <= MSG_IFOK_S;
							msg_last_reg <= MSG_IFOK_E;
						end else begin
							msg_idx_reg  <= MSG_IFBAD_S;
							msg_last_reg <= MSG_IFBAD_E;
						end
						ret_reg     <= line_hi_reg ? ST_LOOP : ST_LINE;
						line_hi_reg <= 1'b1;
						loop_ch_reg <= LOOP_FIRST;
						state_reg   <= ST_MSG;
					end
				end
				ST_LOOP: begin
					if (tx_take) begin
						loop_ch_reg <= loop_ch_reg + 8'h1;
						if (loop_ch_reg == LOOP_LAST) begin
							state_reg <= ST_LWAIT;
						end
					end
				end
				ST_LWAIT: begin
					if (wait_reg == LWAIT_CYC) begin
						state_reg <= ST_DRAIN;
					end
				end
				ST_DRAIN: begin
					if ((cnt_reg == 14'h0) && !rd_pend_reg && !prn_valid && !fifo_out_valid) begin
						state_reg   <= test_on_reg ? ST_REV : ST_RUN;
						rev_idx_reg <= 1'b0;
						line_hi_reg <= 1'b0;
					end
				end
				default: begin
					state_reg <= ST_RUN;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// [bench/spif_top_sva.sv]
// Port-level concurrent checks of the serial printer interface
`timescale 1ns/1ps
`default_nettype none
module spif_top_chk #(
	parameter int unsigned BIT_CYC = 16
) (
	input wire logic       sys_clk,
	input wire logic       reset_n,
	input wire logic       txd_out,
	input wire logic       dtr_out,
	input wire logic       rts_out,
	input wire logic       secondary_busy_status_out,
	input wire logic       diag_mode,
	input wire logic       xon_mode,
	input wire logic       prn_ready,
	input wire logic       prn_valid,
	input wire logic [7:0] prn_data
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	logic [31:0] low_reg;
	// Length of the current low stretch on transmit
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			low_reg <= 32'h0;
		else
			low_reg <= txd_out ? 32'h0 : low_reg + 32'h1;
	end
	AST_PRN_HOLD: assert property (prn_valid && !prn_ready |=> prn_valid && $stable(prn_data))
		else $error("printer byte changed before it was taken");
	AST_CTRL_PAIR: assert property (dtr_out == rts_out)
		else $error("ready and request lines disagree");
	AST_BUSY_FOLLOW: assert property (!dtr_out |-> !secondary_busy_status_out)
		else $error("busy line high while control lines low");
	AST_BUSY_XON: assert property (xon_mode && dtr_out |-> secondary_busy_status_out)
		else $error("busy line dropped in in-band mode");
	AST_QUIET_TX: assert property (!diag_mode && !xon_mode |-> txd_out)
		else $error("transmit active in line flow mode");
	AST_TX_LOW: assert property ($fell(txd_out) |=> !txd_out [*8])
		else $error("transmit low bit too short");
	AST_TX_HIGH: assert property ($rose(txd_out) |=> txd_out [*8])
		else $error("transmit high bit too short");
	AST_FRAME_LEN: assert property (low_reg <= 9 * BIT_CYC)
		else $error("transmit low longer than start plus data");
endmodule
`default_nettype wire

// [bench/spif_host.sv]
// Host model: sends start-stop characters, honours the busy line
`timescale 1ns/1ps
`default_nettype none
module spif_host #(
	parameter int unsigned BIT_CYC = 16
) (
	input  wire logic sys_clk,
	input  wire logic busy_in,
	output logic      host_txd
);
	// Line idles at mark
	initial host_txd = 1'b1;
	// One character; a bad stop is low only past mid-bit, so the false start that follows is rejected
	task automatic send(input logic [7:0] ch, input logic stop_ok);
		logic [8:0] frame;
		frame = {ch, 1'b0};
		while (busy_in !== 1'b1)
			@(negedge sys_clk);
		for (int i = 0; i < 9; i++) begin
			host_txd = frame[i];
			repeat (BIT_CYC) @(negedge sys_clk);
		end
		host_txd = stop_ok;
		repeat (BIT_CYC * 3 / 4) @(negedge sys_clk);
		host_txd = 1'b1;
		repeat (2 * BIT_CYC) @(negedge sys_clk);
	endtask
endmodule
`default_nettype wire

// [bench/tb_serial_printer_interface.sv]
// Bench: receive path, both flow modes and the looped self-test
`timescale 1ns/1ps
`default_nettype none
module tb_serial_printer_interface;
	import spif_pkg::*;
	localparam int unsigned BITC = 16;
	logic            sys_clk = 1'b0;
	logic            reset_n = 1'b0;
	logic            diag_mode = 1'b0;
	logic            xon_mode = 1'b0;
	logic            sel_switch = 1'b0;
	logic            prn_ready = 1'b1;
	logic            plug = 1'b0;
	logic            cd_fault = 1'b0;
	int              n_errors = 0;
	int              n_checks = 0;
	logic [7:0]      got[$];
	logic [7:0]      exp[$];
	wire logic       host_txd, txd_out, dtr_out, rts_out, busy_out, prn_valid, ovr;
	wire logic [7:0] prn_data;
	wire logic rxd_in = plug ? txd_out : host_txd;
	wire logic dsr_in = plug ? dtr_out : 1'b1;
	wire logic cts_in = plug ? rts_out : 1'b1;
	wire logic cd_in  = plug ? (busy_out & ~cd_fault) : 1'b1;

	always #4 sys_clk = ~sys_clk;

	spif_top #(.BIT_CYC(BITC), .FW_REV(16'h3437)) u_dut ( // Revision arbitrary
		.sys_clk(sys_clk), .reset_n(reset_n), .rxd_in(rxd_in), .dsr_in(dsr_in),
		.cts_in(cts_in), .cd_in(cd_in), .diag_mode(diag_mode),
		.sel_switch(sel_switch), .xon_mode(xon_mode), .prn_ready(prn_ready),
		.txd_out(txd_out), .dtr_out(dtr_out), .rts_out(rts_out),
		.secondary_busy_status_out(busy_out), .prn_data(prn_data),
		.prn_valid(prn_valid), .rx_overrun(ovr));
	spif_host #(.BIT_CYC(BITC)) u_host (
		.sys_clk(sys_clk), .busy_in(busy_out), .host_txd(host_txd));

	// Record bytes the printer takes; design updates land after this read
	always @(posedge sys_clk) begin
		if (reset_n && prn_valid === 1'b1 && prn_ready)
			got.push_back(prn_data);
	end

	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected t=%0t byte %h want %h", $time, g, e);
		end
	endtask
	task automatic chk_bit(input logic g, input logic e);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected t=%0t level %b want %b", $time, g, e);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic do_reset(input logic d, input logic x);
		@(negedge sys_clk);
		reset_n = 1'b0;
		diag_mode = d;
		xon_mode = x;
		repeat (12) @(negedge sys_clk);
		// Cleared in reset: a self-test prints its first bytes soon after release
		got.delete();
		reset_n = 1'b1;
		repeat (10) @(negedge sys_clk);
	endtask
	task automatic push_str(input string s);
		foreach (s[i])
			exp.push_back(s[i]);
	endtask
	// Bounded wait for the expected bytes; strict also refuses extras
	task automatic match(input int lim, input bit strict);
		int k;
		k = 0;
		while (got.size() < exp.size() && k < lim) begin
			@(negedge sys_clk);
			k++;
		end
		if (strict)
			repeat (40 * BITC) @(negedge sys_clk);
		foreach (exp[i])
			chk_byte(got.size() > 0 ? got.pop_front() : 8'hxx, exp[i]);
		if (strict)
			chk_bit(got.size() == 0, 1'b1);
		exp.delete();
	endtask
	// Ready/busy mode: stalled printer, awkward data, framing fault
	task automatic t_normal();
		do_reset(1'b0, 1'b0);
		chk_bit(dtr_out, 1'b1);
		chk_bit(busy_out, 1'b1);
		chk_bit(rts_out, 1'b1);
		prn_ready = 1'b0;
		u_host.send(8'h00, 1'b1);
		u_host.send(8'hff, 1'b1);
		u_host.send(8'ha5, 1'b1);
		chk_bit(prn_valid, 1'b1);
		chk_byte(prn_data, 8'h00);
		prn_ready = 1'b1;
		exp = {8'h00, 8'hff, 8'ha5};
		match(2000, 1'b1);
		u_host.send(8'h3c, 1'b0);
		u_host.send(8'hc3, 1'b1);
		exp = {8'hc3};
		match(2000, 1'b1);
		chk_bit(ovr, 1'b0);
	endtask
	// In-band mode keeps the busy line ready
	task automatic t_xon();
		do_reset(1'b0, 1'b1);
		u_host.send(8'h7e, 1'b1);
		exp = {8'h7e};
		match(2000, 1'b1);
		chk_bit(busy_out, 1'b1);
	endtask
	task automatic push_pass(input bit hi_bad);
		push_str("47LOOP TESTOKIF OK");
		push_str(hi_bad ? "IF BAD" : "IF OK");
		for (int c = 32; c < 128; c++)
			exp.push_back(8'(c));
	endtask
	// Self-test: good pass, then a broken carrier line and a stop request
	task automatic t_self();
		plug = 1'b1;
		do_reset(1'b1, 1'b0);
		push_pass(1'b0);
		match(60000, 1'b0);
		cd_fault = 1'b1;
		sel_switch = 1'b1;
		repeat (4) @(negedge sys_clk);
		sel_switch = 1'b0;
		push_pass(1'b1);
		match(60000, 1'b1);
		chk_bit(ovr, 1'b0);
	endtask

	// Watchdog sized well past the expected run
	initial begin
		repeat (90000) @(posedge sys_clk);
		n_errors++;
		$display("unexpected t=%0t watchdog expired", $time);
		finish_test();
	end
	// Main sequence
	initial begin
		t_normal();
		t_xon();
		t_self();
		finish_test();
	end
endmodule

bind spif_top spif_top_chk #(.BIT_CYC(BIT_CYC)) u_chk (
	.sys_clk(sys_clk), .reset_n(reset_n), .txd_out(txd_out), .dtr_out(dtr_out),
	.rts_out(rts_out), .secondary_busy_status_out(secondary_busy_status_out),
	.diag_mode(diag_mode), .xon_mode(xon_mode), .prn_ready(prn_ready),
	.prn_valid(prn_valid), .prn_data(prn_data));
`default_nettype wire
